// ==== core_support_pkg.sv ====
package core_support_pkg;
  localparam int STACK_DEPTH = 16;
  localparam int PC_W = 15;
  localparam int SP_W = 5;
  localparam logic [4:0] SP_RESET = 5'h1F;
  localparam logic [4:0] SP_TOP = 5'h0F;
  localparam logic [4:0] SP_EMPTY = 5'h1F;
  // register byte offsets (axi4-lite)
  localparam logic [7:0] REG_STACK_POINTER = 8'h00;
  localparam logic [7:0] REG_TOS_LOW = 8'h04;
  localparam logic [7:0] REG_TOS_HIGH = 8'h08;
  localparam logic [7:0] REG_CONTROL = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam int CTRL_FAULT_RESET_BIT = 0;
  localparam int STAT_OVF_BIT = 0;
  localparam int STAT_UNF_BIT = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // indirect address map
  localparam logic [15:0] TRAD_LAST = 16'h0FFF;
  localparam logic [15:0] LIN_BASE = 16'h2000;
  localparam logic [15:0] LIN_LAST = 16'h29AF;
  localparam logic [6:0] GPR_SPAN = 7'h50;
  localparam logic [6:0] GPR_START = 7'h20;
  localparam logic [6:0] BANK_SIZE = 7'h00;
  localparam logic [11:0] WIN0_ADDR = 12'h000;
  localparam logic [11:0] WIN1_ADDR = 12'h001;
  localparam int FLASH_BIT = 15;
  localparam int FLASH_EXTRA_CYCLES = 1;
  typedef enum logic [1:0] {IDLE, DATA, FLASH_WAIT, DONE} ind_state_t;
endpackage

// ==== indirect_decode.sv ====
`timescale 1ns/1ps
module indirect_decode
  import core_support_pkg::*;
(
  input wire logic [15:0] ptr, // file_select_pointer
  output logic is_flash, // flash region
  output logic is_window, // points at a window register
  output logic is_mapped, // data or linear hit
  output logic [11:0] data_addr, // absolute data address
  output logic [14:0] flash_addr // flash word address
);
  logic [15:0] off;
  logic [5:0] bank;
  logic [6:0] rem;
  always_comb
  begin
    off = ptr - LIN_BASE;
    bank = 6'(off / 16'(GPR_SPAN));
    rem = 7'(off % 16'(GPR_SPAN));
    is_flash = ptr[FLASH_BIT];
    flash_addr = ptr[14:0];
    is_window = 1'b0;
    is_mapped = 1'b0;
    data_addr = 12'h000;
    if (!ptr[FLASH_BIT] && ptr <= TRAD_LAST)
    begin
      data_addr = ptr[11:0];
      is_mapped = 1'b1;
    end
    else if (!ptr[FLASH_BIT] && ptr >= LIN_BASE && ptr <= LIN_LAST)
    begin
      // bank stride 128; common bytes 70h..7Fh never reached
      data_addr = {bank[4:0], rem + GPR_START};
      is_mapped = 1'b1;
    end
    is_window = is_mapped && (data_addr == WIN0_ADDR || data_addr == WIN1_ADDR);
  end
endmodule

// ==== core_support.sv ====
`timescale 1ns/1ps
// Behaviour
// - stack pointer selects entry shown through top-of-stack registers
// - top of stack is readable/writable high and low registers, 15 bits
// - stack pointer is five bits wide for fault detection
// - calls and interrupts increment pointer; returns decrement it
// - push increments then stores; pop restores then decrements
// - pointer always addresses most recently used entry
// - with fault reset enabled, overflow or underflow resets and flags
// - window access redirects to pointer address; window holds nothing
// - pointer at a window register reads zero, write suppressed
// - pointer is high byte concatenated with low byte
// - pointer 0x000-0xFFF maps to absolute data addresses
// - pointer 0x2000-0x29AF is linear concatenated 80-byte bank RAM
// - unimplemented locations read 0x00 through the window
// - linear view excludes the 16 common bytes
// - pointer msb selects flash word; read returns low eight bits
// - indirect writes to flash region never modify flash
// - flash region access takes one extra instruction cycle
// - stack holds sixteen 15-bit entries apart from memory spaces
// - without fault reset the stack wraps circularly
// - overflow and underflow flags set regardless of fault reset
module core_support
  import core_support_pkg::*;
(
  input wire logic sys_clk, // core clock
  input wire logic nrst, // async reset, low
  input wire logic push_req, // call, indexed call or interrupt
  input wire logic pop_req, // return of any kind
  input wire logic [14:0] push_pc, // pc to store
  output logic [14:0] pop_pc, // restored pc, valid with pop_valid
  output logic pop_valid, // pulse after pop
  output logic stack_fault_reset, // pulse: device reset request
  input wire logic ind_req, // window access strobe
  input wire logic ind_write, // 1 write, 0 read
  input wire logic [7:0] pointer_high_byte, // pointer high
  input wire logic [7:0] pointer_low_byte, // pointer low
  input wire logic [7:0] ind_wdata, // write data
  output logic [7:0] ind_rdata, // read data
  output logic ind_done, // pulse: access complete
  output logic mem_we, // data memory write strobe
  output logic mem_re, // data memory read strobe
  output logic [11:0] mem_addr, // data memory address
  output logic [7:0] mem_wdata, // data memory write data
  input wire logic [7:0] mem_rdata, // data memory read data, valid in strobe cycle
  output logic flash_re, // flash read strobe
  output logic [14:0] flash_addr, // flash word address
  input wire logic [13:0] flash_rdata, // flash word, valid in strobe cycle
  input wire logic [31:0] s_axi_awaddr, // axi write address
  input wire logic s_axi_awvalid, // axi
  output logic s_axi_awready, // axi
  input wire logic [31:0] s_axi_wdata, // axi
  input wire logic [3:0] s_axi_wstrb, // axi
  input wire logic s_axi_wvalid, // axi
  output logic s_axi_wready, // axi
  output logic [1:0] s_axi_bresp, // axi
  output logic s_axi_bvalid, // axi
  input wire logic s_axi_bready, // axi
  input wire logic [31:0] s_axi_araddr, // axi
  input wire logic s_axi_arvalid, // axi
  output logic s_axi_arready, // axi
  output logic [31:0] s_axi_rdata, // axi
  output logic [1:0] s_axi_rresp, // axi
  output logic s_axi_rvalid, // axi
  input wire logic s_axi_rready // axi
);
  import core_support_pkg::*;

  logic [PC_W-1:0] stack_mem [STACK_DEPTH];
  logic [4:0] stack_pointer_r;
  logic fault_reset_en_r, ovf_r, unf_r;
  logic [4:0] sp_inc, sp_dec;
  logic push_ovf, pop_unf;
  logic [14:0] top_of_stack, dec_faddr;
  logic [7:0] aw_addr_r;
  logic aw_have_r, w_have_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic wr_fire, wr_sp, wr_tos_lo, wr_tos_hi;
  logic clr_ovf, clr_unf;
  ind_state_t ind_state_r;
  logic [15:0] ptr;
  logic dec_flash, dec_window, dec_mapped;
  logic [11:0] dec_addr;

  // 5-bit wrap: 1Fh is empty, so first push lands at entry 0
  assign sp_inc = stack_pointer_r + 5'h01;
  assign sp_dec = stack_pointer_r - 5'h01;
  assign push_ovf = push_req && (stack_pointer_r == SP_TOP);
  // a push in the same cycle wins, so the pop never faults then
  assign pop_unf = pop_req && !push_req && (stack_pointer_r == SP_EMPTY);
  assign top_of_stack = stack_mem[stack_pointer_r[3:0]];

  function automatic logic lane_hit(input logic [7:0] a, input logic [7:0] reg_off);
    lane_hit = (a[7:2] == reg_off[7:2]);
  endfunction

  assign wr_fire = aw_have_r && w_have_r && !s_axi_bvalid;
  assign wr_sp = wr_fire && lane_hit(aw_addr_r, REG_STACK_POINTER) && w_strb_r[0];
  assign wr_tos_lo = wr_fire && lane_hit(aw_addr_r, REG_TOS_LOW) && w_strb_r[0];
  assign wr_tos_hi = wr_fire && lane_hit(aw_addr_r, REG_TOS_HIGH) && w_strb_r[0];
  assign clr_ovf = wr_fire && lane_hit(aw_addr_r, REG_STATUS) && w_strb_r[0]
    && w_data_r[STAT_OVF_BIT];
  assign clr_unf = wr_fire && lane_hit(aw_addr_r, REG_STATUS) && w_strb_r[0]
    && w_data_r[STAT_UNF_BIT];

  // stack pointer: core push/pop win over a software write in the same cycle
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      stack_pointer_r <= SP_RESET;
    else if ((push_ovf || pop_unf) && fault_reset_en_r)
      stack_pointer_r <= SP_RESET;
    else if (push_req)
      stack_pointer_r <= {1'b0, sp_inc[3:0]};
    else if (pop_req)
      stack_pointer_r <= sp_dec;
    else if (wr_sp)
      stack_pointer_r <= w_data_r[4:0];
  end

  // storage: no reset, contents are undefined at power-up
  always_ff @(posedge sys_clk)
  begin
    if (push_req)
      stack_mem[sp_inc[3:0]] <= push_pc;
    else if (wr_tos_lo)
      stack_mem[stack_pointer_r[3:0]][7:0] <= w_data_r[7:0];
    else if (wr_tos_hi)
      stack_mem[stack_pointer_r[3:0]][14:8] <= w_data_r[6:0];
  end

  // pop presents the entry read before the pointer moves
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pop_pc <= 15'h0000;
      pop_valid <= 1'b0;
    end
    else
    begin
      pop_valid <= pop_req && !push_req;
      if (pop_req)
        pop_pc <= top_of_stack;
    end
  end

  // flags sticky; hardware set wins over software clear
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ovf_r <= 1'b0;
      unf_r <= 1'b0;
      stack_fault_reset <= 1'b0;
    end
    else
    begin
      if (push_ovf)
        ovf_r <= 1'b1;
      else if (clr_ovf)
        ovf_r <= 1'b0;
      if (pop_unf && !push_req)
        unf_r <= 1'b1;
      else if (clr_unf)
        unf_r <= 1'b0;
      stack_fault_reset <= fault_reset_en_r && (push_ovf || (pop_unf && !push_req));
    end
  end

  // fault reset enable stands in for the configuration bit, default enabled
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      fault_reset_en_r <= 1'b1;
    else if (wr_fire && lane_hit(aw_addr_r, REG_CONTROL) && w_strb_r[0])
      fault_reset_en_r <= w_data_r[CTRL_FAULT_RESET_BIT];
  end

  // axi write channel: address and data taken in either order
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr[7:0];
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr_r > REG_STATUS + 8'h03) ? RESP_SLVERR : RESP_OKAY;
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // axi read channel
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= (s_axi_araddr[7:0] > REG_STATUS + 8'h03) ? RESP_SLVERR : RESP_OKAY;
      case (s_axi_araddr[7:2])
        REG_STACK_POINTER[7:2]: s_axi_rdata <= {27'h0, stack_pointer_r};
        REG_TOS_LOW[7:2]: s_axi_rdata <= {24'h0, top_of_stack[7:0]};
        REG_TOS_HIGH[7:2]: s_axi_rdata <= {25'h0, top_of_stack[14:8]};
        REG_CONTROL[7:2]: s_axi_rdata <= {31'h0, fault_reset_en_r};
        REG_STATUS[7:2]: s_axi_rdata <= {30'h0, unf_r, ovf_r};
        default: s_axi_rdata <= 32'h0000_0000;
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  assign ptr = {pointer_high_byte, pointer_low_byte};
  indirect_decode indirect_decode_inst (
    .ptr(ptr),
    .is_flash(dec_flash),
    .is_window(dec_window),
    .is_mapped(dec_mapped),
    .data_addr(dec_addr),
    .flash_addr(dec_faddr)
  );

  // indirect access: data takes 2 cycles to done, flash one more
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ind_state_r <= IDLE;
      ind_done <= 1'b0;
      ind_rdata <= 8'h00;
      mem_we <= 1'b0;
      mem_re <= 1'b0;
      mem_addr <= 12'h000;
      mem_wdata <= 8'h00;
      flash_re <= 1'b0;
      flash_addr <= 15'h0000;
    end
    else
    begin
      mem_we <= 1'b0;
      mem_re <= 1'b0;
      flash_re <= 1'b0;
      ind_done <= 1'b0;
      case (ind_state_r)
        IDLE:
          if (ind_req)
          begin
            mem_addr <= dec_addr;
            mem_wdata <= ind_wdata;
            flash_addr <= dec_faddr;
            ind_rdata <= 8'h00;
            if (dec_flash)
            begin
              flash_re <= !ind_write;
              ind_state_r <= FLASH_WAIT;
            end
            else
            begin
              mem_we <= ind_write && dec_mapped && !dec_window;
              mem_re <= !ind_write && dec_mapped && !dec_window;
              ind_state_r <= DATA;
            end
          end
        DATA:
        begin
          if (mem_re)
            ind_rdata <= mem_rdata;
          ind_done <= 1'b1;
          ind_state_r <= IDLE;
        end
        FLASH_WAIT:
        begin
          if (flash_re)
            ind_rdata <= flash_rdata[7:0];
          ind_state_r <= DONE;
        end
        DONE:
        begin
          ind_done <= 1'b1;
          ind_state_r <= IDLE;
        end
        default: ind_state_r <= IDLE;
      endcase
    end
  end

  push_inc_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    push_req && !push_ovf |=> stack_pointer_r == $past(sp_inc) % 5'h10)
    else $error("push did not increment pointer");
  pop_dec_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    pop_req && !push_req && !pop_unf |=> stack_pointer_r == $past(sp_dec))
    else $error("pop did not decrement pointer");
  push_store_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    push_req && !push_ovf |=> top_of_stack == $past(push_pc))
    else $error("pushed pc not at top");
  pop_value_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    pop_req && !push_req |=> pop_valid && pop_pc == $past(top_of_stack))
    else $error("pop value wrong");
  fault_reset_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    push_ovf && fault_reset_en_r |=> stack_fault_reset && ovf_r)
    else $error("overflow reset missing");
  wrap_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    push_ovf && !fault_reset_en_r |=> stack_pointer_r == 5'h00 && !stack_fault_reset)
    else $error("stack did not wrap");
  unf_flag_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    pop_unf && !push_req |=> unf_r)
    else $error("underflow flag not set");
  window_block_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    ind_state_r == IDLE && ind_req && dec_window |=> !mem_we && !mem_re)
    else $error("window self access not blocked");
  flash_nowrite_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    ind_state_r == IDLE && ind_req && dec_flash |=> !mem_we)
    else $error("flash region write leaked");
  flash_extra_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    ind_state_r == IDLE && ind_req && dec_flash |=> !ind_done ##1 !ind_done ##1 ind_done)
    else $error("flash timing wrong");
  data_time_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    ind_state_r == IDLE && ind_req && !dec_flash |=> !ind_done ##1 ind_done)
    else $error("data timing wrong");
  cov_push_c: cover property (@(posedge sys_clk) disable iff (!nrst) push_req ##1 pop_req);
  cov_ovf_c: cover property (@(posedge sys_clk) disable iff (!nrst) push_ovf);
  cov_flash_c: cover property (@(posedge sys_clk) disable iff (!nrst) flash_re);
endmodule

// ==== mem_model.sv ====
`timescale 1ns/1ps
module mem_model
(
  input wire logic sys_clk, // core clock
  input wire logic mem_we, // data write strobe
  input wire logic mem_re, // data read strobe
  input wire logic [11:0] mem_addr, // data address
  input wire logic [7:0] mem_wdata, // write data
  output logic [7:0] mem_rdata, // read data, strobe cycle
  input wire logic flash_re, // flash read strobe
  input wire logic [14:0] flash_addr, // flash word address
  output logic [13:0] flash_rdata // flash word, strobe cycle
);
  logic [7:0] mem [4096];
  logic [13:0] fword;
  initial
  begin
    for (int i = 0; i < 4096; i++) mem[i] = 8'(i) ^ 8'h5A;
  end
  always @(posedge sys_clk)
  begin
    if (mem_we === 1'b1) mem[mem_addr] <= mem_wdata;
  end
  // answer stands while the strobe does; otherwise inverted, so a mistimed sample fails
  assign fword = {flash_addr[5:0], flash_addr[7:0] ^ 8'hC3};
  assign mem_rdata = (mem_re === 1'b1) ? mem[mem_addr] : ~mem[mem_addr];
  assign flash_rdata = (flash_re === 1'b1) ? fword : ~fword;
endmodule

// ==== core_support_tb.sv ====
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin \
    checked++; \
    if ((g) !== (e)) \
    begin \
      n_fail++; \
      $display("Error %s exp %0h got %0h", nm, e, g); \
    end \
  end
module core_support_tb;
  import core_support_pkg::*;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic push_req = 1'b0, pop_req = 1'b0, ind_req = 1'b0, ind_write = 1'b0;
  logic [14:0] push_pc = 15'h0000;
  logic [7:0] pointer_high_byte = 8'h00, pointer_low_byte = 8'h00, ind_wdata = 8'h00;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [14:0] pop_pc, flash_addr, lf;
  logic pop_valid, stack_fault_reset, ind_done, mem_we, mem_re, flash_re;
  logic [7:0] ind_rdata, mem_wdata, mem_rdata, id, lw;
  logic [11:0] mem_addr, la;
  logic [13:0] flash_rdata;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [31:0] s_axi_rdata, rv;
  int n_fail = 0, checked = 0, cyc = 0, lat = 0;
  int n_re = 0, n_we = 0, n_fr = 0, n_flt = 0;

  core_support core_support_inst (.*);
  mem_model mem_model_inst (.*);

  always #5 sys_clk = ~sys_clk;

  // strobes are counted so that a missing or extra access shows up
  always @(posedge sys_clk)
  begin
    if (mem_re === 1'b1 || mem_we === 1'b1) la = mem_addr;
    if (mem_we === 1'b1) lw = mem_wdata;
    if (flash_re === 1'b1) lf = flash_addr;
    n_re += int'(mem_re === 1'b1);
    n_we += int'(mem_we === 1'b1);
    n_fr += int'(flash_re === 1'b1);
    n_flt += int'(stack_fault_reset === 1'b1);
  end

  task automatic finish_test;
    $display("checked %0d failed %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      finish_test();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever
    begin
      @(posedge sys_clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1)
      begin
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever
    begin
      @(posedge sys_clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1)
      begin
        rv = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    `CHK($sformatf("reg_%0h", a), e, rv[7:0])
    `CHK("rresp", RESP_OKAY, rs)
  endtask

  task automatic push(input logic [14:0] pc);
    @(posedge sys_clk);
    push_req <= 1'b1;
    push_pc <= pc;
    @(posedge sys_clk);
    push_req <= 1'b0;
  endtask

  // an underflowing pop returns no meaningful entry, so chk is cleared there
  task automatic pop(input logic [14:0] e, input bit chk);
    @(posedge sys_clk);
    pop_req <= 1'b1;
    @(posedge sys_clk);
    pop_req <= 1'b0;
    #1;
    if (chk)
    begin
      `CHK("pop_valid", 1'b1, pop_valid)
      `CHK("pop_pc", e, pop_pc)
    end
  endtask

  task automatic ind(input logic w, input logic [15:0] p, input logic [7:0] d);
    @(posedge sys_clk);
    ind_req <= 1'b1;
    ind_write <= w;
    pointer_high_byte <= p[15:8];
    pointer_low_byte <= p[7:0];
    ind_wdata <= d;
    @(posedge sys_clk);
    ind_req <= 1'b0;
    // the edge that takes ind_req counts as cycle 1
    lat = 1;
    do
    begin
      @(posedge sys_clk);
      #1;
      lat++;
    end
    while (ind_done !== 1'b1 && lat < 8);
    id = ind_rdata;
  endtask

  task automatic t_regs;
    rdc(REG_STACK_POINTER, 8'h1F);
    rdc(REG_CONTROL, 8'h01);
    rdc(REG_STATUS, 8'h00);
    rd(8'h20);
    `CHK("rresp_unmapped", RESP_SLVERR, rs)
    wr(8'h20, 32'h0);
    `CHK("bresp_unmapped", RESP_SLVERR, rs)
    $display("test regs done");
  endtask

  task automatic t_stack;
    push(15'h1234);
    push(15'h7ABC);
    push(15'h0055);
    rdc(REG_STACK_POINTER, 8'h02);
    rdc(REG_TOS_LOW, 8'h55);
    rdc(REG_TOS_HIGH, 8'h00);
    wr(REG_STACK_POINTER, 32'h0);
    rdc(REG_TOS_LOW, 8'h34);
    rdc(REG_TOS_HIGH, 8'h12);
    wr(REG_STACK_POINTER, 32'h2);
    wr(REG_TOS_LOW, 32'h99);
    wr(REG_TOS_HIGH, 32'h3F);
    `CHK("bresp", RESP_OKAY, rs)
    pop(15'h3F99, 1);
    pop(15'h7ABC, 1);
    pop(15'h1234, 1);
    rdc(REG_STACK_POINTER, 8'h1F);
    $display("test stack done");
  endtask

  task automatic t_fault;
    int f0;
    f0 = n_flt;
    pop(15'h0, 0);
    repeat (3) @(posedge sys_clk);
    #1;
    `CHK("fault_pulses", f0 + 1, n_flt)
    rdc(REG_STATUS, 8'h02);
    rdc(REG_STACK_POINTER, 8'h1F);
    wr(REG_STATUS, 32'h3);
    rdc(REG_STATUS, 8'h00);
    wr(REG_STACK_POINTER, 32'h0F);
    push(15'h0ABC);
    repeat (3) @(posedge sys_clk);
    #1;
    `CHK("fault_pulses", f0 + 2, n_flt)
    rdc(REG_STATUS, 8'h01);
    rdc(REG_STACK_POINTER, 8'h1F);
    wr(REG_STATUS, 32'h3);
    $display("test fault done");
  endtask

  task automatic t_wrap;
    int f0;
    wr(REG_CONTROL, 32'h0);
    f0 = n_flt;
    for (int i = 0; i < 17; i++) push(15'(i + 1));
    rdc(REG_STACK_POINTER, 8'h00);
    rdc(REG_TOS_LOW, 8'h11);
    rdc(REG_STATUS, 8'h01);
    pop(15'h0011, 1);
    pop(15'h0, 0);
    rdc(REG_STACK_POINTER, 8'h1E);
    rdc(REG_STATUS, 8'h03);
    `CHK("fault_pulses", f0, n_flt)
    wr(REG_STATUS, 32'h3);
    wr(REG_CONTROL, 32'h1);
    wr(REG_STACK_POINTER, 32'h1F);
    $display("test wrap done");
  endtask

  task automatic t_ind;
    int s0;
    ind(1, 16'h0123, 8'hA7);
    `CHK("lat_data", 2, lat)
    `CHK("mem_addr", 12'h123, la)
    `CHK("mem_wdata", 8'hA7, lw)
    ind(0, 16'h0123, 8'h00);
    `CHK("rdata", 8'hA7, id)
    ind(0, 16'h0456, 8'h00);
    `CHK("rdata", 8'h56 ^ 8'h5A, id)
    ind(0, 16'h2050, 8'h00);
    `CHK("lin_addr", 12'h0A0, la)
    ind(0, 16'h2055, 8'h00);
    `CHK("lin_addr", 12'h0A5, la)
    ind(0, 16'h29AF, 8'h00);
    `CHK("lin_data", 8'h6F ^ 8'h5A, id)
    s0 = n_re + n_we + n_fr;
    ind(0, 16'h0001, 8'h00);
    `CHK("win_rd", 8'h00, id)
    ind(1, 16'h0000, 8'h11);
    `CHK("win_wr", s0, n_re + n_we + n_fr)
    ind(0, 16'h1000, 8'h00);
    `CHK("unimpl_rd", 8'h00, id)
    ind(1, 16'hFFFF, 8'h22);
    `CHK("no_strobe", s0, n_re + n_we + n_fr)
    ind(0, 16'h8005, 8'h00);
    `CHK("lat_flash", 3, lat)
    `CHK("flash_addr", 15'h0005, lf)
    `CHK("flash_rd", 8'h05 ^ 8'hC3, id)
    $display("test indirect done");
  endtask

  initial
  begin
    repeat (10) @(posedge sys_clk);
    nrst <= 1'b1;
    t_regs();
    t_stack();
    // wrap first: it fills every entry, so the underflow pop reads a known value
    t_wrap();
    t_fault();
    t_ind();
    finish_test();
  end
endmodule
